/* File: rtl/flash_addr_step.sv */
`timescale 1ns/1ps
module flash_addr_step
  import flash_pkg::*;
(
  input wire logic [flash_pkg::PAGE_BITS-1:0] page,
  input wire logic [flash_pkg::BYTE_BITS-1:0] byte_idx,
  input wire logic page_opt,
  output logic [flash_pkg::PAGE_BITS-1:0] page_next,
  output logic [flash_pkg::BYTE_BITS-1:0] byte_next
);
  logic [BYTE_BITS-1:0] byte_last;

  assign byte_last = page_opt ? BYTE_LAST_OPT : BYTE_LAST_DEF;

  always_comb
  begin
    page_next = page;
    byte_next = byte_idx + 9'h001;
    if (byte_idx >= byte_last)
    begin
      byte_next = '0;
      // next page, no gap
      page_next = page + 12'h001;
      if (page == PAGE_LAST)
      begin
        page_next = '0;
      end
    end
  end
endmodule : flash_addr_step

/* File: rtl/flash_link_if.sv */
`timescale 1ns/1ps
interface flash_link_if;
  logic cs_n;
  logic sck;
  logic si;
  logic so_o;
  logic so_oe;
  logic so;

  // released output shows the inverse of the last bit
  assign so = so_oe ? so_o : ~so_o;

  modport device (
    input cs_n,
    input sck,
    input si,
    output so_o,
    output so_oe
  );

  modport host (
    output cs_n,
    output sck,
    output si,
    input so
  );
endinterface : flash_link_if

/* File: rtl/flash_pkg.sv */
package flash_pkg;

  localparam int OP_BITS = 8;
  localparam int ADDR_BITS = 24;
  localparam int PAGE_BITS = 12;
  localparam int BYTE_BITS = 9;
  localparam int CNT_BITS = 6;
  localparam int BIT_IDX_BITS = 3;
  localparam int LEN_BITS = 16;
  localparam int DIV_BITS = 8;

  localparam logic [7:0] OP_READ_TOP = 8'h1B;
  localparam logic [7:0] OP_READ_HIGH = 8'h0B;
  localparam logic [7:0] OP_READ_LOW = 8'h03;
  localparam logic [7:0] OP_READ_LOW_POWER = 8'h01;

  localparam logic [CNT_BITS-1:0] DUMMY_TOP = 6'h02;
  localparam logic [CNT_BITS-1:0] DUMMY_HIGH = 6'h01;
  localparam logic [CNT_BITS-1:0] DUMMY_NONE = 6'h00;

  // header bit positions, counted from zero on rising edges
  localparam logic [CNT_BITS-1:0] OP_LAST = 6'h07;
  localparam logic [CNT_BITS-1:0] ADDR_LAST = 6'h1F;
  localparam logic [CNT_BITS-1:0] CNT_MAX = 6'h3F;
  localparam logic [BIT_IDX_BITS-1:0] BIT_LAST = 3'h7;
  localparam logic [BIT_IDX_BITS-1:0] BIT_FIRST = 3'h0;

  localparam logic [BYTE_BITS-1:0] BYTE_LAST_DEF = 9'h0FF;
  localparam logic [BYTE_BITS-1:0] BYTE_LAST_OPT = 9'h107;
  localparam logic [PAGE_BITS-1:0] PAGE_LAST = 12'hFFF;

  // serial clock limits per opcode, in MHz
  localparam int CLK_MHZ = 100;
  localparam int TOP_READ_CLOCK_LIMIT_MHZ = 16;
  localparam int HIGH_READ_CLOCK_LIMIT_MHZ = 12;
  localparam int LOW_READ_CLOCK_LIMIT_MHZ = 8;
  localparam int LOW_POWER_READ_CLOCK_LIMIT_MHZ = 4;
  localparam int HALF_MIN = 3;

  function automatic int half_of(input int lim_mhz);
    int h;
    h = (CLK_MHZ + 2 * lim_mhz - 1) / (2 * lim_mhz);
    return (h < HALF_MIN) ? HALF_MIN : h;
  endfunction : half_of

  localparam logic [DIV_BITS-1:0] HALF_TOP = DIV_BITS'(half_of(TOP_READ_CLOCK_LIMIT_MHZ));
  localparam logic [DIV_BITS-1:0] HALF_HIGH = DIV_BITS'(half_of(HIGH_READ_CLOCK_LIMIT_MHZ));
  localparam logic [DIV_BITS-1:0] HALF_LOW = DIV_BITS'(half_of(LOW_READ_CLOCK_LIMIT_MHZ));
  localparam logic [DIV_BITS-1:0] HALF_LOW_POWER =
    DIV_BITS'(half_of(LOW_POWER_READ_CLOCK_LIMIT_MHZ));

  function automatic logic op_valid(input logic [7:0] op);
    return (op == OP_READ_TOP) || (op == OP_READ_HIGH) ||
           (op == OP_READ_LOW) || (op == OP_READ_LOW_POWER);
  endfunction : op_valid

  function automatic logic [CNT_BITS-1:0] dummy_bytes(input logic [7:0] op);
    case (op)
      OP_READ_TOP: return DUMMY_TOP;
      OP_READ_HIGH: return DUMMY_HIGH;
      default: return DUMMY_NONE;
    endcase
  endfunction : dummy_bytes

  // index of the last header bit
  function automatic logic [CNT_BITS-1:0] hdr_last(input logic [7:0] op);
    logic [CNT_BITS-1:0] dummy;
    dummy = dummy_bytes(op);
    return ADDR_LAST + {dummy[CNT_BITS-4:0], 3'h0};
  endfunction : hdr_last

  function automatic logic [DIV_BITS-1:0] half_for(input logic [7:0] op);
    case (op)
      OP_READ_TOP: return HALF_TOP;
      OP_READ_HIGH: return HALF_HIGH;
      OP_READ_LOW: return HALF_LOW;
      default: return HALF_LOW_POWER;
    endcase
  endfunction : half_for

  typedef enum logic [1:0] {
    HOST_IDLE,
    HOST_HDR,
    HOST_DATA
  } host_state_t;

endpackage : flash_pkg

/* File: rtl/flash_read_device.sv */
`timescale 1ns/1ps
module flash_read_device
  import flash_pkg::*;
(
  flash_link_if.device link,
  input wire logic arst_n,
  input wire logic page_264,
  output logic [flash_pkg::PAGE_BITS-1:0] arr_page,
  output logic [flash_pkg::BYTE_BITS-1:0] arr_byte,
  input wire logic [7:0] arr_data,
  output logic reading
);
  import flash_pkg::*;

  logic frame_rst_n;
  logic [CNT_BITS-1:0] cnt_q;
  logic [ADDR_BITS-2:0] sh_q;
  logic [OP_BITS-1:0] op_q;
  logic data_q;
  logic [BIT_IDX_BITS-1:0] bit_q;
  logic [PAGE_BITS-1:0] page_q;
  logic [BYTE_BITS-1:0] byte_q;
  logic opt_meta_q;
  logic opt_q;
  logic [7:0] out_q;
  logic so_q;
  logic oe_q;
  logic [ADDR_BITS-1:0] addr_in;
  logic [PAGE_BITS-1:0] page_d;
  logic [BYTE_BITS-1:0] byte_d;

  ////////////////////////////////////////////////////////////////////////////
  // frame reset: select high clears the whole link side
  assign frame_rst_n = arst_n & ~link.cs_n;

  assign addr_in = {sh_q, link.si};

  ////////////////////////////////////////////////////////////////////////////
  // page size strap, synchronised to the serial clock
  always_ff @(posedge link.sck or negedge frame_rst_n)
  begin
    if (!frame_rst_n)
    begin
      opt_meta_q <= 1'b0;
      opt_q <= 1'b0;
    end
    else
    begin
      opt_meta_q <= page_264;
      opt_q <= opt_meta_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // header capture on rising edges
  always_ff @(posedge link.sck or negedge frame_rst_n)
  begin
    if (!frame_rst_n)
    begin
      cnt_q <= '0;
    end
    else if (!data_q && cnt_q != CNT_MAX)
    begin
      cnt_q <= cnt_q + 6'h01;
    end
  end

  always_ff @(posedge link.sck or negedge frame_rst_n)
  begin
    if (!frame_rst_n)
    begin
      sh_q <= '0;
    end
    else if (!data_q)
    begin
      // msb first into the shifter
      sh_q <= addr_in[ADDR_BITS-2:0];
    end
  end

  always_ff @(posedge link.sck or negedge frame_rst_n)
  begin
    if (!frame_rst_n)
    begin
      op_q <= '0;
    end
    else if (cnt_q == OP_LAST)
    begin
      op_q <= addr_in[OP_BITS-1:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // data phase starts after the last header bit
  always_ff @(posedge link.sck or negedge frame_rst_n)
  begin
    if (!frame_rst_n)
    begin
      data_q <= 1'b0;
    end
    else if (!data_q && op_valid(op_q) && cnt_q == hdr_last(op_q))
    begin
      // dummy count by opcode, values ignored
      data_q <= 1'b1;
    end
  end

  always_ff @(posedge link.sck or negedge frame_rst_n)
  begin
    if (!frame_rst_n)
    begin
      bit_q <= '0;
    end
    else if (data_q)
    begin
      bit_q <= bit_q + 3'h1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // address counter
  flash_addr_step u_step (
    .page(page_q),
    .byte_idx(byte_q),
    .page_opt(opt_q),
    .page_next(page_d),
    .byte_next(byte_d)
  );

  always_ff @(posedge link.sck or negedge frame_rst_n)
  begin
    if (!frame_rst_n)
    begin
      page_q <= '0;
      byte_q <= '0;
    end
    else if (cnt_q == ADDR_LAST && !data_q)
    begin
      if (opt_q)
      begin
        page_q <= addr_in[BYTE_BITS+PAGE_BITS-1:BYTE_BITS];
        byte_q <= addr_in[BYTE_BITS-1:0];
      end
      else
      begin
        // top bits unused
        page_q <= addr_in[PAGE_BITS+BYTE_BITS-2:BYTE_BITS-1];
        byte_q <= {1'b0, addr_in[BYTE_BITS-2:0]};
      end
    end
    else if (data_q && bit_q == BIT_LAST)
    begin
      page_q <= page_d;
      byte_q <= byte_d;
    end
  end

  assign arr_page = page_q;
  assign arr_byte = byte_q;
  assign reading = data_q;

  ////////////////////////////////////////////////////////////////////////////
  // output shifter on falling edges
  always_ff @(negedge link.sck or negedge frame_rst_n)
  begin
    if (!frame_rst_n)
    begin
      out_q <= '0;
      so_q <= 1'b0;
    end
    else if (data_q)
    begin
      if (bit_q == BIT_FIRST)
      begin
        // straight from the array port, no buffer touched
        so_q <= arr_data[7];
        out_q <= {arr_data[6:0], 1'b0};
      end
      else
      begin
        so_q <= out_q[7];
        out_q <= {out_q[6:0], 1'b0};
      end
    end
  end

  always_ff @(negedge link.sck or negedge frame_rst_n)
  begin
    if (!frame_rst_n)
    begin
      oe_q <= 1'b0;
    end
    else if (data_q)
    begin
      oe_q <= 1'b1;
    end
  end

  assign link.so_o = so_q;
  assign link.so_oe = oe_q;
endmodule : flash_read_device

/* File: rtl/flash_read_host.sv */
`timescale 1ns/1ps
module flash_read_host
  import flash_pkg::*;
(
  input wire logic clk,
  input wire logic arst_n,
  flash_link_if.host link,
  input wire logic start,
  input wire logic [flash_pkg::OP_BITS-1:0] cmd,
  input wire logic [flash_pkg::ADDR_BITS-1:0] addr,
  input wire logic [flash_pkg::LEN_BITS-1:0] nbytes,
  output logic busy,
  output logic [7:0] rd_data,
  output logic rd_valid,
  output logic done
);
  import flash_pkg::*;

  host_state_t state_q;
  logic [DIV_BITS-1:0] div_q;
  logic [DIV_BITS-1:0] half_q;
  logic sck_q;
  logic cs_n_q;
  logic [OP_BITS+ADDR_BITS-1:0] tx_q;
  logic [CNT_BITS-1:0] cnt_q;
  logic [CNT_BITS-1:0] last_q;
  logic [BIT_IDX_BITS-1:0] bit_q;
  logic [7:0] rx_q;
  logic [LEN_BITS-1:0] left_q;
  logic so_meta_q;
  logic so_s_q;
  logic tick;

  ////////////////////////////////////////////////////////////////////////////
  // serial output synchroniser
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      so_meta_q <= 1'b0;
      so_s_q <= 1'b0;
    end
    else
    begin
      so_meta_q <= link.so;
      so_s_q <= so_meta_q;
    end
  end

  assign tick = (state_q != HOST_IDLE) && (div_q == half_q - 8'h01);

  ////////////////////////////////////////////////////////////////////////////
  // sequencer, clock divider and shifters
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      state_q <= HOST_IDLE;
      div_q <= '0;
      half_q <= HALF_LOW_POWER;
      sck_q <= 1'b0;
      cs_n_q <= 1'b1;
      tx_q <= '0;
      cnt_q <= '0;
      last_q <= '0;
      bit_q <= '0;
      rx_q <= '0;
      left_q <= '0;
      rd_data <= '0;
      busy <= 1'b0;
      rd_valid <= 1'b0;
      done <= 1'b0;
    end
    else
    begin
      rd_valid <= 1'b0;
      done <= 1'b0;
      div_q <= tick ? '0 : div_q + 8'h01;
      case (state_q)
        HOST_IDLE:
        begin
          div_q <= '0;
          if (start && nbytes != '0)
          begin
            state_q <= HOST_HDR;
            // select low before first clock
            cs_n_q <= 1'b0;
            busy <= 1'b1;
            half_q <= half_for(cmd);
            tx_q <= {cmd, addr};
            last_q <= hdr_last(cmd);
            cnt_q <= '0;
            bit_q <= '0;
            left_q <= nbytes;
          end
        end
        HOST_HDR:
        begin
          if (tick)
          begin
            sck_q <= ~sck_q;
            if (!sck_q)
            begin
              cnt_q <= cnt_q + 6'h01;
              if (cnt_q == last_q)
              begin
                state_q <= HOST_DATA;
              end
            end
            else
            begin
              // msb first, dummy bits zero
              tx_q <= {tx_q[OP_BITS+ADDR_BITS-2:0], 1'b0};
            end
          end
        end
        HOST_DATA:
        begin
          if (tick)
          begin
            sck_q <= ~sck_q;
            if (!sck_q)
            begin
              // sample on rising edge
              rx_q <= {rx_q[6:0], so_s_q};
              bit_q <= bit_q + 3'h1;
              if (bit_q == BIT_LAST)
              begin
                rd_data <= {rx_q[6:0], so_s_q};
                rd_valid <= 1'b1;
                left_q <= left_q - 16'h0001;
              end
            end
            else if (left_q == '0)
            begin
              cs_n_q <= 1'b1;
              busy <= 1'b0;
              state_q <= HOST_IDLE;
              done <= 1'b1;
            end
          end
        end
        default:
        begin
          state_q <= HOST_IDLE;
          cs_n_q <= 1'b1;
          busy <= 1'b0;
          sck_q <= 1'b0;
        end
      endcase
    end
  end

  assign link.cs_n = cs_n_q;
  assign link.sck = sck_q;
  assign link.si = tx_q[OP_BITS+ADDR_BITS-1];
endmodule : flash_read_host

/* File: tb/flash_link_assertions.sv */
`timescale 1ns/1ps
module flash_link_assertions
  import flash_pkg::*;
(
  input wire logic clk,
  input wire logic arst_n,
  input wire logic cs_n,
  input wire logic sck,
  input wire logic si,
  input wire logic so_o,
  input wire logic so_oe,
  input wire logic so
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);
  logic sck_q;
  logic [15:0] rise_cnt;
  logic [7:0] op_q;
  logic [7:0] lvl_cnt;
  logic [15:0] hdr_n;
  logic [7:0] half_n;
  ////////////////////////////////////////////////////////////////////////////
  // serial clock edges and opcode seen on the wire
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n) sck_q <= 1'b0;
    else sck_q <= sck;
  end
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n) rise_cnt <= 16'h0000;
    else if (cs_n) rise_cnt <= 16'h0000;
    else if (sck && !sck_q) rise_cnt <= rise_cnt + 16'h0001;
  end
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n) op_q <= 8'h00;
    else if (!cs_n && sck && !sck_q && rise_cnt < 16'h0008) op_q <= {op_q[6:0], si};
  end
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n) lvl_cnt <= 8'h00;
    else if (sck != sck_q) lvl_cnt <= 8'h01;
    else if (lvl_cnt != 8'hFF) lvl_cnt <= lvl_cnt + 8'h01;
  end
  always_comb
  begin
    case (op_q)
      OP_READ_TOP: hdr_n = 16'h0030;
      OP_READ_HIGH: hdr_n = 16'h0028;
      default: hdr_n = 16'h0020;
    endcase
    case (op_q)
      OP_READ_TOP: half_n = HALF_TOP;
      OP_READ_HIGH: half_n = HALF_HIGH;
      OP_READ_LOW: half_n = HALF_LOW;
      default: half_n = HALF_LOW_POWER;
    endcase
  end
  ////////////////////////////////////////////////////////////////////////////
  first_data_a: assert property ($rose(so_oe) |-> rise_cnt == hdr_n)
    else $error("data phase started at wrong header length");
  oe_idle_a: assert property (cs_n |-> !so_oe)
    else $error("output driven while deselected");
  oe_hold_a: assert property ($fell(so_oe) |-> cs_n)
    else $error("output released inside frame");
  sck_idle_a: assert property (cs_n |-> !sck)
    else $error("serial clock not idle low");
  so_fall_a: assert property ((!cs_n && $changed(so_o)) |-> $fell(sck))
    else $error("output bit changed off falling edge");
  so_stable_a: assert property ((so_oe && $rose(sck)) |-> $stable(so))
    else $error("output bit moved at rising edge");
  oe_rise_a: assert property ($rose(so_oe) |-> $fell(sck))
    else $error("drive enable rose off falling edge");
  frame_end_a: assert property ($rose(cs_n) |-> rise_cnt >= hdr_n + 16'h0008 &&
    rise_cnt[2:0] == 3'h0)
    else $error("select released mid byte or mid header");
  sck_rate_a: assert property ((!cs_n && sck != sck_q && rise_cnt > 16'h0008) |->
    lvl_cnt >= half_n)
    else $error("serial clock faster than opcode limit");
endmodule : flash_link_assertions

/* File: tb/test_serial_flash_continuous_read.sv */
`timescale 1ns/1ps
`define CHECK(got, exp) begin comparisons++; if ((got) !== (exp)) begin miscompares++; \
  $display("MISMATCH t=%0t got=%0h exp=%0h", $time, got, exp); end end
module test_serial_flash_continuous_read;
  import flash_pkg::*;
  logic clk, arst_n, start, page_264, busy, rd_valid, done, reading;
  logic [7:0] cmd, rd_data, arr_data;
  logic [23:0] addr;
  logic [15:0] nbytes;
  logic [11:0] arr_page;
  logic [8:0] arr_byte;
  logic [31:0] hdr_cap;
  int hdr_cnt, miscompares, comparisons, cycles, i;
  logic [7:0] ops [4] = '{OP_READ_TOP, OP_READ_HIGH, OP_READ_LOW, OP_READ_LOW_POWER};
  flash_link_if flash_link_if_i ();
  flash_read_host flash_read_host_i (.clk(clk), .arst_n(arst_n), .link(flash_link_if_i.host),
    .start(start), .cmd(cmd), .addr(addr), .nbytes(nbytes), .busy(busy), .rd_data(rd_data),
    .rd_valid(rd_valid), .done(done));
  flash_read_device flash_read_device_i (.link(flash_link_if_i.device), .arst_n(arst_n),
    .page_264(page_264), .arr_page(arr_page), .arr_byte(arr_byte), .arr_data(arr_data),
    .reading(reading));
  flash_link_assertions flash_link_assertions_i (.clk(clk), .arst_n(arst_n),
    .cs_n(flash_link_if_i.cs_n), .sck(flash_link_if_i.sck), .si(flash_link_if_i.si),
    .so_o(flash_link_if_i.so_o), .so_oe(flash_link_if_i.so_oe), .so(flash_link_if_i.so));
  ////////////////////////////////////////////////////////////////////////////
  // array contents and expected stream
  function automatic logic [7:0] pat(input logic [11:0] pg, input logic [8:0] by);
    return pg[7:0] ^ by[7:0] ^ {pg[11:8], by[8], 3'h5};
  endfunction : pat
  function automatic logic [7:0] exp_data(input logic big, input logic [23:0] a, input int k);
    logic [11:0] pg;
    logic [8:0] by;
    pg = big ? a[20:9] : a[19:8];
    by = big ? a[8:0] : {1'b0, a[7:0]};
    for (int j = 0; j < k; j++)
    begin
      if (by >= (big ? 9'h107 : 9'h0FF))
      begin
        by = 9'h000;
        pg = pg + 12'h001;
      end
      else by = by + 9'h001;
    end
    return pat(pg, by);
  endfunction : exp_data
  assign arr_data = pat(arr_page, arr_byte);
  ////////////////////////////////////////////////////////////////////////////
  // header bits as seen on the wire
  always @(posedge flash_link_if_i.sck or posedge flash_link_if_i.cs_n)
  begin
    if (flash_link_if_i.cs_n) hdr_cnt <= 0;
    else if (hdr_cnt < 32)
    begin
      hdr_cap <= {hdr_cap[30:0], flash_link_if_i.si};
      hdr_cnt <= hdr_cnt + 1;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic run(input logic [7:0] op, input logic [23:0] a, input int n, input logic big,
    input logic chk);
    int w;
    @(posedge clk);
    page_264 <= big;
    cmd <= op;
    addr <= a;
    nbytes <= 16'(n);
    start <= 1'b1;
    @(posedge clk);
    start <= 1'b0;
    #1;
    `CHECK(busy, 1'b1)
    for (int k = 0; k < n; k++)
    begin
      w = 0;
      do
      begin
        @(posedge clk);
        #1;
        w++;
      end
      while (rd_valid !== 1'b1 && w < 3000);
      if (w >= 3000) miscompares++;
      if (chk) `CHECK(rd_data, exp_data(big, a, k))
      `CHECK(reading, chk)
    end
    w = 0;
    do
    begin
      @(posedge clk);
      #1;
      w++;
    end
    while (done !== 1'b1 && w < 3000);
    if (w >= 3000) miscompares++;
    `CHECK(busy, 1'b0)
    `CHECK(hdr_cap, {op, a})
    `CHECK(reading, 1'b0)
  endtask : run
  task end_of_test;
    if (miscompares == 0 && comparisons > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : end_of_test
  ////////////////////////////////////////////////////////////////////////////
  always #5 clk = ~clk;
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 80000)
    begin
      miscompares++;
      end_of_test;
    end
  end
  initial
  begin
    clk = 1'b0;
    arst_n = 1'b0;
    start = 1'b0;
    page_264 = 1'b0;
    cmd = 8'h00;
    addr = 24'h000000;
    nbytes = 16'h0000;
    miscompares = 0;
    comparisons = 0;
    repeat (4) @(posedge clk);
    arst_n <= 1'b1;
    void'($urandom(80));
    for (i = 0; i < 4; i++) run(ops[i], 24'h0000FE, 3, 1'b0, 1'b1);
    run(OP_READ_HIGH, 24'h0FFFFF, 2, 1'b0, 1'b1);
    run(OP_READ_TOP, 24'h1FFF06, 3, 1'b1, 1'b1);
    run(OP_READ_LOW_POWER, 24'hE00107, 2, 1'b1, 1'b1);
    run(8'h5A, 24'h012345, 1, 1'b0, 1'b0);
    for (i = 0; i < 8; i++) run(ops[$urandom % 4], 24'($urandom), 1 + $urandom % 5,
      1'($urandom), 1'b1);
    end_of_test;
  end
endmodule : test_serial_flash_continuous_read
